/* analog_comparator_control.sv */
// Register slave and control of one analog comparator
//
// Contract
// - Enable bit runs comparator, leaves others
// - Pin drive bit drives result onto pin
// - Invert bit inverts the comparator result
// - Inversion also feeds the edge detector
// - Status bit reads current comparator result
// - Edge field: none, rising, falling, both
// - Positive select: ladder reference or pin
// - Negative select: own pin, pins, bandgap
// - Unimplemented bits read zero, ignore writes
`timescale 1ns/10ps
`include "cmp_ctrl_consts.svh"

module analog_comparator_control (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // AXI4-Lite slave
    input  wire cmp_ctrl_pkg::axi_req_type     axiReq,
    output cmp_ctrl_pkg::axi_rsp_type          axiRsp,
    // Analog core
    input  wire logic                          rawResult,
    output cmp_ctrl_pkg::analog_ctrl_type      analogCtrl,
    // Output pin
    output logic                               cmpOutputPinOut,
    output logic                               cmpOutputPinOe,
    // Interrupt
    output logic                               irq
);
    import cmp_ctrl_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        control_type     ctrl;
        logic            irqStatus;
        logic            irqMask;
        logic            awHeld;
        logic [7:0]      awAddr;
        logic            wHeld;
        logic [31:0]     wData;
        logic [3:0]      wStrb;
        axi_rsp_type     rsp;
        analog_ctrl_type analog;
        logic            pinOut;
        logic            pinOe;
        logic            irqOut;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic        cmpResult;
    logic        edgeEvent;
    logic [31:0] ctrlWord;
    logic [31:0] rdWord;
    logic        rdOk;
    logic        wrOk;
    logic        doWrite;
    logic        clearIrq;

    // ****************************************************************
    // Result path
    // ****************************************************************
    cmp_edge_detect u_edge (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .cmpInvert     (s_q.ctrl.cmpInvert),
        .irqEdgeSelect (s_q.ctrl.irqEdgeSelect),
        .rawResult     (rawResult),
        .cmpResult     (cmpResult),
        .edgeEvent     (edgeEvent)
    );

    // ****************************************************************
    // Read view of the control register
    // ****************************************************************
    always_comb begin
        ctrlWord = 32'h0000_0000;
        ctrlWord[`CMP_ENABLE_BIT]    = s_q.ctrl.cmpEnable;
        ctrlWord[`CMP_PIN_DRIVE_BIT] = s_q.ctrl.cmpPinDriveEn;
        ctrlWord[`CMP_INVERT_BIT]    = s_q.ctrl.cmpInvert;
        ctrlWord[`CMP_RESULT_BIT]    = cmpResult;
        ctrlWord[`CMP_EDGE_HI_BIT:`CMP_EDGE_LO_BIT] = s_q.ctrl.irqEdgeSelect;
        ctrlWord[`CMP_POS_SEL_BIT]   = s_q.ctrl.posInputSelect;
        ctrlWord[`CMP_NEG_SEL_HI_BIT:`CMP_NEG_SEL_LO_BIT] = s_q.ctrl.negInputSelect;
    end

    always_comb begin
        rdOk   = 1'b1;
        rdWord = 32'h0000_0000;
        case (axiReq.araddr)
            `CMP_CONTROL_OFFSET:    rdWord = ctrlWord;
            `CMP_IRQ_STATUS_OFFSET: rdWord = {31'h0000_0000, s_q.irqStatus};
            `CMP_IRQ_MASK_OFFSET:   rdWord = {31'h0000_0000, s_q.irqMask};
            default:                rdOk   = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d      = s_q;
        doWrite  = 1'b0;
        clearIrq = 1'b0;
        wrOk     = (s_q.awAddr == `CMP_CONTROL_OFFSET) ||
                   (s_q.awAddr == `CMP_IRQ_STATUS_OFFSET) ||
                   (s_q.awAddr == `CMP_IRQ_MASK_OFFSET);

        // Address and data captured in either order
        if (axiReq.awvalid && s_q.rsp.awready) begin
            s_d.awHeld      = 1'b1;
            s_d.awAddr      = axiReq.awaddr;
            s_d.rsp.awready = 1'b0;
        end
        if (axiReq.wvalid && s_q.rsp.wready) begin
            s_d.wHeld      = 1'b1;
            s_d.wData      = axiReq.wdata;
            s_d.wStrb      = axiReq.wstrb;
            s_d.rsp.wready = 1'b0;
        end

        // Write executes once both halves are held
        if (s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid) begin
            doWrite         = 1'b1;
            s_d.awHeld      = 1'b0;
            s_d.wHeld       = 1'b0;
            s_d.rsp.bvalid  = 1'b1;
            s_d.rsp.bresp   = wrOk ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
        end
        if (s_q.rsp.bvalid && axiReq.bready) begin
            s_d.rsp.bvalid  = 1'b0;
            s_d.rsp.awready = 1'b1;
            s_d.rsp.wready  = 1'b1;
        end

        if (doWrite) begin
            case (s_q.awAddr)
                `CMP_CONTROL_OFFSET: begin
                    if (s_q.wStrb[1]) begin
                        s_d.ctrl.cmpEnable     = s_q.wData[`CMP_ENABLE_BIT];
                        s_d.ctrl.cmpPinDriveEn = s_q.wData[`CMP_PIN_DRIVE_BIT];
                        s_d.ctrl.cmpInvert     = s_q.wData[`CMP_INVERT_BIT];
                    end
                    if (s_q.wStrb[0]) begin
                        s_d.ctrl.irqEdgeSelect  = edge_select_type'(
                            s_q.wData[`CMP_EDGE_HI_BIT:`CMP_EDGE_LO_BIT]);
                        s_d.ctrl.posInputSelect = s_q.wData[`CMP_POS_SEL_BIT];
                        s_d.ctrl.negInputSelect = neg_select_type'(
                            s_q.wData[`CMP_NEG_SEL_HI_BIT:`CMP_NEG_SEL_LO_BIT]);
                    end
                end
                `CMP_IRQ_STATUS_OFFSET: clearIrq = s_q.wStrb[0] && s_q.wData[0];
                `CMP_IRQ_MASK_OFFSET: begin
                    if (s_q.wStrb[0]) begin
                        s_d.irqMask = s_q.wData[0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Sticky status, set wins over clear
        if (clearIrq) begin
            s_d.irqStatus = 1'b0;
        end
        if (edgeEvent) begin
            s_d.irqStatus = 1'b1;
        end

        // Read channel
        if (axiReq.arvalid && s_q.rsp.arready) begin
            s_d.rsp.arready = 1'b0;
            s_d.rsp.rvalid  = 1'b1;
            s_d.rsp.rdata   = rdWord;
            s_d.rsp.rresp   = rdOk ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
        end
        if (s_q.rsp.rvalid && axiReq.rready) begin
            s_d.rsp.rvalid  = 1'b0;
            s_d.rsp.arready = 1'b1;
        end

        // Analog controls and pin
        s_d.analog.powerOn     = s_d.ctrl.cmpEnable;
        s_d.analog.posIsLadder = s_d.ctrl.posInputSelect;
        s_d.analog.negSelect   = s_d.ctrl.negInputSelect;
        s_d.pinOe  = s_d.ctrl.cmpPinDriveEn;
        s_d.pinOut = s_d.ctrl.cmpPinDriveEn & cmpResult;
        s_d.irqOut = s_d.irqStatus & s_d.irqMask;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q                      <= '0;
            s_q.ctrl.irqEdgeSelect   <= edge_select_type'(`CMP_EDGE_RESET);
            s_q.ctrl.negInputSelect  <= neg_select_type'(`CMP_NEG_SEL_RESET);
            s_q.analog.negSelect     <= neg_select_type'(`CMP_NEG_SEL_RESET);
            s_q.rsp.awready          <= 1'b1;
            s_q.rsp.wready           <= 1'b1;
            s_q.rsp.arready          <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign axiRsp          = s_q.rsp;
    assign analogCtrl      = s_q.analog;
    assign cmpOutputPinOut = s_q.pinOut;
    assign cmpOutputPinOe  = s_q.pinOe;
    assign irq             = s_q.irqOut;
endmodule

/* cmp_ctrl_consts.svh */
// Register offsets, field positions and reset values of the comparator control block
`ifndef CMP_CTRL_CONSTS_SVH
`define CMP_CTRL_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CMP_CONTROL_OFFSET   8'h00
`define CMP_IRQ_STATUS_OFFSET 8'h04
`define CMP_IRQ_MASK_OFFSET  8'h08

// ****************************************************************
// Control register field positions
// ****************************************************************
`define CMP_ENABLE_BIT       15
`define CMP_PIN_DRIVE_BIT    14
`define CMP_INVERT_BIT       13
`define CMP_RESULT_BIT       8
`define CMP_EDGE_HI_BIT      7
`define CMP_EDGE_LO_BIT      6
`define CMP_POS_SEL_BIT      4
`define CMP_NEG_SEL_HI_BIT   1
`define CMP_NEG_SEL_LO_BIT   0

// ****************************************************************
// Reset values and bus response codes
// ****************************************************************
`define CMP_EDGE_RESET       2'h3
`define CMP_NEG_SEL_RESET    2'h3
`define CMP_RESP_OKAY        2'h0
`define CMP_RESP_SLVERR      2'h2

`endif

/* cmp_ctrl_pkg.sv */
// Types shared by the comparator control block
package cmp_ctrl_pkg;

    // ****************************************************************
    // Edge selection and input selection
    // ****************************************************************
    typedef enum logic [1:0] {
        EDGE_NONE    = 2'h0,
        EDGE_RISING  = 2'h1,
        EDGE_FALLING = 2'h2,
        EDGE_BOTH    = 2'h3
    } edge_select_type;

    typedef enum logic [1:0] {
        NEG_OWN_PIN   = 2'h0,
        NEG_POS_PIN_A = 2'h1,
        NEG_POS_PIN_B = 2'h2,
        NEG_BANDGAP   = 2'h3
    } neg_select_type;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    typedef struct packed {
        logic            cmpEnable;
        logic            cmpPinDriveEn;
        logic            cmpInvert;
        edge_select_type irqEdgeSelect;
        logic            posInputSelect;
        neg_select_type  negInputSelect;
    } control_type;

    // ****************************************************************
    // Analog core controls
    // ****************************************************************
    typedef struct packed {
        logic           powerOn;
        logic           posIsLadder;
        neg_select_type negSelect;
    } analog_ctrl_type;

    // ****************************************************************
    // AXI4-Lite channels
    // ****************************************************************
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_type;

endpackage

/* cmp_edge_detect.sv */
// Synchroniser, polarity and edge detection of the comparator result
`timescale 1ns/10ps

module cmp_edge_detect (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    // Controls
    input  wire logic                          cmpInvert,
    input  wire cmp_ctrl_pkg::edge_select_type irqEdgeSelect,
    // Raw comparator output
    input  wire logic                          rawResult,
    // Results
    output logic                               cmpResult,
    output logic                               edgeEvent
);
    import cmp_ctrl_pkg::*;

    typedef struct packed {
        logic syncA;
        logic syncB;
        logic prevAdj;
        logic evt;
    } edge_state_type;

    edge_state_type s_q;
    edge_state_type s_d;
    logic           adjusted;

    always_comb begin
        s_d       = s_q;
        s_d.syncA = rawResult;
        s_d.syncB = s_q.syncA;
        adjusted  = s_q.syncB ^ cmpInvert;
        s_d.prevAdj = adjusted;
        case (irqEdgeSelect)
            EDGE_RISING:  s_d.evt = adjusted & ~s_q.prevAdj;
            EDGE_FALLING: s_d.evt = ~adjusted & s_q.prevAdj;
            EDGE_BOTH:    s_d.evt = adjusted ^ s_q.prevAdj;
            default:      s_d.evt = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmpResult = s_q.prevAdj;
    assign edgeEvent = s_q.evt;
endmodule

/* analog_comparator_chk.sv */
// Checker of bus, pin and reset behaviour of the comparator control block
`timescale 1ns/10ps

module analog_comparator_chk (
    // Clock and reset
    input wire logic                          ref_clk,
    input wire logic                          reset,
    // Register bus
    input wire cmp_ctrl_pkg::axi_req_type     axiReq,
    input wire cmp_ctrl_pkg::axi_rsp_type     axiRsp,
    // Core and pins
    input wire logic                          rawResult,
    input wire cmp_ctrl_pkg::analog_ctrl_type analogCtrl,
    input wire logic                          cmpOutputPinOut,
    input wire logic                          cmpOutputPinOe,
    input wire logic                          irq
);
    import cmp_ctrl_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ****************************************************************
    // Sequences and properties
    // ****************************************************************
    sequence s_wr; axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready; endsequence
    sequence s_rd; axiReq.arvalid && axiRsp.arready; endsequence
    property p_wr_lat; s_wr |-> ##2 axiRsp.bvalid; endproperty
    property p_wr_busy; s_wr |=> !axiRsp.awready && !axiRsp.wready; endproperty
    property p_rd_lat; s_rd |=> axiRsp.rvalid; endproperty
    property p_rd_hold; axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata); endproperty
    property p_b_hold; axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp); endproperty
    property p_unmapped; s_rd ##0 !(axiReq.araddr inside {8'h00, 8'h04, 8'h08})
        |=> axiRsp.rresp == 2'h2 && axiRsp.rdata == 32'h0; endproperty
    property p_zero_bits; axiRsp.rvalid && axiRsp.rresp == 2'h0
        |-> axiRsp.rdata[31:16] == 16'h0 && axiRsp.rdata[12:9] == 4'h0; endproperty
    property p_pin_off; !cmpOutputPinOe |-> !cmpOutputPinOut; endproperty
    property p_reset_state; $fell(reset) |-> !analogCtrl.powerOn && !analogCtrl.posIsLadder
        && analogCtrl.negSelect == NEG_BANDGAP && !cmpOutputPinOe && !irq; endproperty
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    a_wr_busy: assert property (p_wr_busy) else $error("write taken twice");
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    a_zero_bits: assert property (p_zero_bits) else $error("unused bits not zero");
    a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule

bind analog_comparator_control analog_comparator_chk i_chk (.ref_clk(ref_clk), .reset(reset),
    .axiReq(axiReq), .axiRsp(axiRsp), .rawResult(rawResult), .analogCtrl(analogCtrl),
    .cmpOutputPinOut(cmpOutputPinOut), .cmpOutputPinOe(cmpOutputPinOe), .irq(irq));

/* cmp_core_model.sv */
// Behavioural comparator core with its input selectors
`timescale 1ns/10ps

module cmp_core_model (
    // Controls
    input  wire cmp_ctrl_pkg::analog_ctrl_type analogCtrl,
    // Analog levels
    input  wire logic [7:0]                    ladderLevel,
    input  wire logic [7:0]                    posPinLevel,
    input  wire logic [7:0]                    negPinLevel,
    input  wire logic [7:0]                    otherPinLevel,
    input  wire logic [7:0]                    bandgapLevel,
    // Raw output
    output logic                               rawResult
);
    import cmp_ctrl_pkg::*;
    logic [7:0] posLevel;
    logic [7:0] negLevel;
    always_comb begin
        posLevel = analogCtrl.posIsLadder ? ladderLevel : posPinLevel;
        case (analogCtrl.negSelect)
            NEG_OWN_PIN:   negLevel = negPinLevel;
            NEG_POS_PIN_A: negLevel = posPinLevel;
            NEG_POS_PIN_B: negLevel = otherPinLevel;
            default:       negLevel = bandgapLevel;
        endcase
        rawResult = analogCtrl.powerOn && (posLevel > negLevel);
    end
endmodule

/* analog_comparator_control_tb.sv */
// Self-checking testbench of the comparator control block
`timescale 1ns/10ps

module analog_comparator_control_tb;
    import cmp_ctrl_pkg::*;
    logic            ref_clk = 1'b0;
    logic            reset = 1'b1;
    axi_req_type     axiReq = '0;
    axi_rsp_type     axiRsp;
    analog_ctrl_type analogCtrl;
    logic            rawResult, pinOut, pinOe, irq, hit, adj;
    logic [63:0]     lv = 64'h0060_2040_1080;
    logic [31:0]     seed = 32'hAB98, ctl = 32'hC3, rdv, v, w, m;
    logic [1:0]      resp;
    bit              lateRdy = 1'b0;
    int              fail_count = 0, n_compared = 0;

    cmp_core_model i_core (.analogCtrl(analogCtrl), .ladderLevel(lv[7:0]),
        .posPinLevel(lv[15:8]), .negPinLevel(lv[23:16]), .otherPinLevel(lv[31:24]),
        .bandgapLevel(lv[39:32]), .rawResult(rawResult));
    analog_comparator_control i_dut (.ref_clk(ref_clk), .reset(reset), .axiReq(axiReq),
        .axiRsp(axiRsp), .rawResult(rawResult), .analogCtrl(analogCtrl),
        .cmpOutputPinOut(pinOut), .cmpOutputPinOe(pinOe), .irq(irq));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // ****************************************************************
    // Model, checks and bus tasks
    // ****************************************************************
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic res();
        logic [7:0] n;
        case (ctl[1:0])
            2'h0: n = lv[23:16];
            2'h1: n = lv[15:8];
            2'h2: n = lv[31:24];
            default: n = lv[39:32];
        endcase
        return (ctl[15] && (ctl[4] ? lv[7:0] : lv[15:8]) > n) ^ ctl[13];
    endfunction
    task chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task finish_test;
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        bit ad, dd, bd;
        ad = 0;
        dd = 0;
        bd = 0;
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.wstrb <= s;
        axiReq.bready <= !lateRdy;
        while (!bd) begin
            @(posedge ref_clk);
            if (axiRsp.awready && !ad) begin
                ad = 1;
                axiReq.awvalid <= 1'b0;
            end
            if (axiRsp.wready && !dd) begin
                dd = 1;
                axiReq.wvalid <= 1'b0;
            end
            if (axiRsp.bvalid && axiReq.bready) begin
                bd = 1;
                resp = axiRsp.bresp;
            end else if (axiRsp.bvalid) begin
                axiReq.bready <= 1'b1;
            end
        end
    endtask
    task rd(input logic [7:0] a);
        bit ac, rc;
        ac = 0;
        rc = 0;
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= !lateRdy;
        while (!rc) begin
            @(posedge ref_clk);
            if (axiRsp.arready && !ac) begin
                ac = 1;
                axiReq.arvalid <= 1'b0;
            end
            if (axiRsp.rvalid && axiReq.rready) begin
                rc = 1;
                rdv = axiRsp.rdata;
                resp = axiRsp.rresp;
            end else if (axiRsp.rvalid) begin
                axiReq.rready <= 1'b1;
            end
        end
    endtask
    task wrCtl(input logic [31:0] d, input logic [3:0] s);
        wr(8'h00, d, s);
        m = 32'hE0D3 & {16'h0, {8{s[1]}}, {8{s[0]}}};
        ctl = (ctl & ~m) | (d & m);
        repeat (8) @(posedge ref_clk);
    endtask
    task chkAll;
        rd(8'h00);
        chk(rdv, {ctl[31:9], res(), ctl[7:0]});
        chk({pinOe, pinOut}, {ctl[14], ctl[14] & res()});
        chk(analogCtrl, {ctl[15], ctl[4], ctl[1:0]});
    endtask
    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        chkAll();
        repeat (40) begin
            v = rnd();
            w = rnd();
            lateRdy = v[0];
            lv <= {v, w};
            wrCtl(rnd(), w[3:0]);
            chkAll();
        end
        lateRdy = 1'b0;
        for (int i = 0; i < 2; i++) begin
            wr(i ? 8'hFC : 8'h0C, 32'hFFFFFFFF, 4'hF);
            chk(resp, 2'h2);
            rd(i ? 8'hFC : 8'h0C);
            chk({rdv, resp}, {32'h0, 2'h2});
        end
        chkAll();
        for (int e = 0; e < 8; e++) begin
            lv <= 64'h0000_0000_0080_0000;
            wrCtl({16'h0, 2'b11, e[0], 5'h0, e[2:1], 6'h0}, 4'hF);
            wr(8'h08, {31'h0, e[2] ^ e[0]}, 4'hF);
            wr(8'h04, 32'h1, 4'hF);
            for (int p = 0; p < 2; p++) begin
                lv[15:8] <= p ? 8'h00 : 8'hFF;
                repeat (8) @(posedge ref_clk);
                adj = (p == 0) ^ e[0];
                hit = e[2:1] == 2'h3 || (e[2:1] == 2'h1 && adj) || (e[2:1] == 2'h2 && !adj);
                rd(8'h04);
                chk(rdv, {31'h0, hit});
                chk(irq, hit & (e[2] ^ e[0]));
                wr(8'h04, 32'h1, 4'hF);
                rd(8'h04);
                chk(rdv, 32'h0);
            end
        end
        finish_test();
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        finish_test();
    end
endmodule
